// *** common/pscs_consts.svh ***
`ifndef PSCS_CONSTS_SVH
`define PSCS_CONSTS_SVH

// ****************************************
// Clock and timing
// ****************************************
`define PSCS_CLK_NS          50
`define PSCS_POR_LONG_MS     100
`define PSCS_POR_SHORT_MS    12
`define PSCS_RESTART_MS      100
`define PSCS_MS_NS           1000000
// Least times round up, longest times round down
`define PSCS_POR_LONG_CYC  (`PSCS_POR_LONG_MS*`PSCS_MS_NS/`PSCS_CLK_NS)
`define PSCS_POR_SHORT_CYC (`PSCS_POR_SHORT_MS*`PSCS_MS_NS/`PSCS_CLK_NS)
`define PSCS_RESTART_CYC   (`PSCS_RESTART_MS*`PSCS_MS_NS/`PSCS_CLK_NS)
`define PSCS_BITCLK_MAX_NS   400
`define PSCS_SUCLK_DLY_NS    (4*`PSCS_BITCLK_MAX_NS)
`define PSCS_SUCLK_DLY_CYC ((`PSCS_SUCLK_DLY_NS+`PSCS_CLK_NS-1)/`PSCS_CLK_NS)
`define PSCS_OSC_NS          100
`define PSCS_SU_TIME_NS      20000
`define PSCS_SU_TICKS ((`PSCS_SU_TIME_NS+`PSCS_OSC_NS-1)/`PSCS_OSC_NS)
`define PSCS_EXT_STARTUP_CYC 4436

// ****************************************
// Register map
// ****************************************
`define PSCS_CTRL_OFS        4'h0
`define PSCS_LENGTH_OFS      4'h4
`define PSCS_STATUS_OFS      4'h8
`define PSCS_BITCNT_OFS      4'hC
`define PSCS_CTRL_EXT_BIT    0
`define PSCS_CTRL_AUTO_BIT   1
`define PSCS_STAT_ERR_BIT    4
`define PSCS_STAT_DEN_BIT    3
`define PSCS_CTRL_RST        2'h0
`define PSCS_LENGTH_RST      32'h0000_1000

// ****************************************
// Bit stream layout
// ****************************************
`define PSCS_SYNC_PATTERN    8'hA5
`define PSCS_SYNC_LAST_IDX   32'h0000_0008
`define PSCS_DONE_EN_IDX     32'h0000_000C

`endif

// *** common/pscs_pkg.sv ***
package pscs_pkg;

  typedef enum logic [2:0] {
    PSCS_POR     = 3'b000,
    PSCS_RESET   = 3'b001,
    PSCS_LOAD    = 3'b010,
    PSCS_STARTUP = 3'b011,
    PSCS_USER    = 3'b100,
    PSCS_ERROR   = 3'b101
  } pscs_stage_e;

  // Filtered pin levels, bit order fixed by the packing below
  typedef struct packed {
    logic pull_dis;
    logic por_sel;
    logic uclk;
    logic data;
    logic bclk;
    logic err_line;
    logic reconfig;
  } pscs_pins_s;

  typedef struct packed {
    logic auto_restart;
    logic ext_clk_sel;
  } pscs_ctrl_s;

endpackage : pscs_pkg

// *** design/pscs_top.sv ***
`timescale 1ns/1ps
`include "pscs_consts.svh"
// Notes on behaviour
// R1: Power-on delay 100 ms, or 12 ms
// R2: During power-on: reset, error line low, tristate
// R3: Loader power-on delay is 100 or 2 ms
// R4: Loader holds error line low meanwhile
// R5: Target must finish power-up before loader
// R6: Release error line after power-on; keep tristate
// R7: Weak pull-ups after power-on unless disabled
// R8: Reset, load, start-up; reset while lines low
// R9: Reconfig rise releases error line, then load
// R10: Outside party may hold either line low
// R11: Loader shifts bits once lines go high
// R12: Capture one bit per bit clock rise
// R13: Release load complete after all bits
// R14: Loader stops when load complete rises
// R15: Start-up clock internal, or external option
// R16: External clock: delay, then 4436 cycles
// R17: External clock up to 100 MHz; code samples it on clk, so each level must last two clk cycles (up to 5 MHz)
// R18: Start-up finished line low until done; code drives it only in load and start-up, with done-enable set
// R19: User mode: pull-ups off, design pins
// R20: Loader restart instruction pulses reconfig line
// R21: On error drive line low, auto restart
// R22: Loader flags failure after 64 clocks
// R23: Synchronise reconfig and error lines
module pscs_top
  import pscs_pkg::*;
#(
  parameter logic [31:0] POR_LONG_CYC  = `PSCS_POR_LONG_CYC,
  parameter logic [31:0] POR_SHORT_CYC = `PSCS_POR_SHORT_CYC,
  parameter logic [31:0] RESTART_CYC   = `PSCS_RESTART_CYC
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Straps
  input  wire logic        powerup_delay_select,
  input  wire logic        weak_pullup_disable,
  // Handshake lines, open drain
  input  wire logic        reconfig_request_line,
  input  wire logic        error_reset_line_i,
  output logic             error_reset_line_o,
  output logic             error_reset_line_oe,
  output logic             load_complete_line_o,
  output logic             load_complete_line_oe,
  output logic             startup_done_line_o,
  output logic             startup_done_line_oe,
  // Serial stream and start-up clock
  input  wire logic        serial_bit_clock,
  input  wire logic        serial_bit_in,
  input  wire logic        external_startup_clock,
  // User pin control
  output logic             user_io_tristate,
  output logic             weak_pullup_en,
  output logic             user_mode
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  localparam int NPIN = 7;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_s1_r;
  logic [NPIN-1:0] pin_s2_r;
  logic [NPIN-1:0] pin_s3_r;
  logic [NPIN-1:0] pin_flt_r;
  pscs_pins_s      pin;

  assign pin_raw = {weak_pullup_disable, powerup_delay_select,
                    external_startup_clock, serial_bit_in,
                    serial_bit_clock, error_reset_line_i,
                    reconfig_request_line};
  assign pin = pscs_pins_s'(pin_flt_r);

  // A level counts only once the second and third stages agree
  for (genvar g = 0; g < NPIN; g++) begin : g_sync
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        pin_s1_r[g]  <= 1'b0;
        pin_s2_r[g]  <= 1'b0;
        pin_s3_r[g]  <= 1'b0;
        pin_flt_r[g] <= 1'b0;
      end else begin
        pin_s1_r[g] <= pin_raw[g];
        pin_s2_r[g] <= pin_s1_r[g];
        pin_s3_r[g] <= pin_s2_r[g];
        if (pin_s2_r[g] == pin_s3_r[g]) begin
          pin_flt_r[g] <= pin_s3_r[g]; // R23
        end
      end
    end
  end

  // Edge detection on the filtered levels
  logic bclk_q_r;
  logic uclk_q_r;
  logic bclk_rise;
  logic uclk_rise;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bclk_q_r <= 1'b0;
      uclk_q_r <= 1'b0;
    end else begin
      bclk_q_r <= pin.bclk;
      uclk_q_r <= pin.uclk;
    end
  end

  assign bclk_rise = pin.bclk & ~bclk_q_r;
  assign uclk_rise = pin.uclk & ~uclk_q_r;

  // ****************************************
  // Register file over APB
  // ****************************************
  pscs_ctrl_s  ctrl_r;
  logic [31:0] length_r;
  logic        err_flag_r;
  logic        err_evt;
  logic        done_en_r;
  logic [31:0] bit_cnt_r;
  pscs_stage_e stage_r;
  logic        apb_wr;
  logic        apb_rd;
  logic        mapped;
  logic [3:0]  ofs;

  assign ofs    = paddr[3:0];
  assign mapped = (paddr[31:4] == 28'h000_0000) && (ofs[1:0] == 2'b00);
  assign apb_wr = psel & penable & pready & pwrite;
  assign apb_rd = psel & penable & ~pready & ~pwrite;

  // Answer comes one cycle into the access phase
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~mapped;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prdata <= 32'h0000_0000;
    end else if (apb_rd) begin
      prdata <= 32'h0000_0000;
      if (mapped) begin
        unique case (ofs)
          `PSCS_CTRL_OFS:   prdata[1:0] <= ctrl_r;
          `PSCS_LENGTH_OFS: prdata      <= length_r;
          `PSCS_STATUS_OFS: prdata[4:0] <= {err_flag_r, done_en_r, stage_r};
          `PSCS_BITCNT_OFS: prdata      <= bit_cnt_r;
          default:          prdata      <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_r   <= `PSCS_CTRL_RST;
      length_r <= `PSCS_LENGTH_RST;
    end else if (apb_wr && mapped) begin
      if (ofs == `PSCS_CTRL_OFS) begin
        ctrl_r <= pwdata[1:0];
      end
      if (ofs == `PSCS_LENGTH_OFS) begin
        length_r <= pwdata;
      end
    end
  end

  // Sticky error flag, write one to clear; a new error wins
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      err_flag_r <= 1'b0;
    end else if (err_evt) begin
      err_flag_r <= 1'b1;
    end else if (apb_wr && mapped && ofs == `PSCS_STATUS_OFS &&
                 pwdata[`PSCS_STAT_ERR_BIT]) begin
      err_flag_r <= 1'b0;
    end
  end

  // ****************************************
  // Stage sequencer
  // ****************************************
  logic [31:0] timer_r;
  logic [12:0] su_cnt_r;
  logic [31:0] shift_r;
  logic [31:0] shift_nxt;
  logic [31:0] bit_cnt_nxt;
  logic        osc_tick_r;
  logic        sync_bad;
  logic        lines_low;
  logic        su_done;

  assign shift_nxt   = {shift_r[30:0], pin.data};
  assign bit_cnt_nxt = bit_cnt_r + 32'h0000_0001;
  assign sync_bad    = (bit_cnt_nxt == `PSCS_SYNC_LAST_IDX) &&
                       (shift_nxt[7:0] != `PSCS_SYNC_PATTERN);
  assign lines_low   = ~pin.reconfig | ~pin.err_line;
  assign err_evt     = (stage_r == PSCS_LOAD) && !lines_low &&
                       bclk_rise && sync_bad;
  assign su_done     = ctrl_r.ext_clk_sel ?
                       (su_cnt_r == 13'(`PSCS_EXT_STARTUP_CYC)) : // R16
                       (su_cnt_r == 13'(`PSCS_SU_TICKS));

  // Stand-in for the 10 MHz internal oscillator
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      osc_tick_r <= 1'b0;
    end else begin
      osc_tick_r <= ~osc_tick_r;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stage_r  <= PSCS_POR;
      timer_r  <= 32'h0000_0000;
      su_cnt_r <= 13'h0000;
    end else begin
      unique case (stage_r)
        PSCS_POR: begin
          // Strap is read after release, through the synchroniser
          if (timer_r >= (pin.por_sel ? POR_SHORT_CYC : POR_LONG_CYC)
                         - 32'h0000_0001) begin // R1 R5
            stage_r <= PSCS_RESET; // R6
            timer_r <= 32'h0000_0000;
          end else begin
            timer_r <= timer_r + 32'h0000_0001;
          end
        end
        PSCS_RESET: begin
          // Held here for as long as either line stays low
          if (!lines_low) begin // R8
            stage_r <= PSCS_LOAD; // R9
          end
        end
        PSCS_LOAD: begin
          if (lines_low) begin
            stage_r <= PSCS_RESET; // R8
          end else if (err_evt) begin
            stage_r <= PSCS_ERROR; // R21
            timer_r <= 32'h0000_0000;
          end else if (bclk_rise && bit_cnt_nxt == length_r) begin
            stage_r  <= PSCS_STARTUP; // R13
            timer_r  <= 32'h0000_0000;
            su_cnt_r <= 13'h0000;
          end
        end
        PSCS_STARTUP: begin
          if (lines_low) begin
            stage_r <= PSCS_RESET; // R8
          end else if (su_done) begin
            stage_r <= PSCS_USER;
          end else if (ctrl_r.ext_clk_sel) begin
            // External clock is ignored until the enable delay ends
            if (timer_r < 32'(`PSCS_SUCLK_DLY_CYC)) begin
              timer_r <= timer_r + 32'h0000_0001; // R16
            end else if (uclk_rise) begin
              su_cnt_r <= su_cnt_r + 13'h0001; // R15
            end
          end else if (osc_tick_r) begin
            su_cnt_r <= su_cnt_r + 13'h0001; // R15
          end
        end
        PSCS_USER: begin
          if (lines_low) begin
            stage_r <= PSCS_RESET; // R8
          end
        end
        PSCS_ERROR: begin
          if (!pin.reconfig) begin
            stage_r <= PSCS_RESET;
          end else if (ctrl_r.auto_restart &&
                       timer_r >= RESTART_CYC - 32'h0000_0001) begin
            stage_r <= PSCS_RESET; // R21
          end else begin
            timer_r <= timer_r + 32'h0000_0001;
          end
        end
        default: begin
          stage_r <= PSCS_POR;
        end
      endcase
    end
  end

  // ****************************************
  // Serial bit capture
  // ****************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      shift_r   <= 32'h0000_0000;
      bit_cnt_r <= 32'h0000_0000;
      done_en_r <= 1'b0;
    end else if (stage_r == PSCS_RESET || stage_r == PSCS_POR) begin
      shift_r   <= 32'h0000_0000;
      bit_cnt_r <= 32'h0000_0000;
      done_en_r <= 1'b0;
    end else if (stage_r == PSCS_LOAD && !lines_low && bclk_rise) begin
      shift_r   <= shift_nxt; // R12
      bit_cnt_r <= bit_cnt_nxt;
      if (bit_cnt_r == `PSCS_DONE_EN_IDX) begin
        done_en_r <= pin.data; // R18
      end
    end
  end

  // ****************************************
  // Pin drivers
  // ****************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      error_reset_line_oe   <= 1'b1;
      load_complete_line_oe <= 1'b1;
      startup_done_line_oe  <= 1'b0;
      error_reset_line_o    <= 1'b0;
      load_complete_line_o  <= 1'b0;
      startup_done_line_o   <= 1'b0;
    end else begin
      error_reset_line_o   <= 1'b0;
      load_complete_line_o <= 1'b0;
      startup_done_line_o  <= 1'b0;
      unique case (stage_r)
        PSCS_POR:   error_reset_line_oe <= 1'b1; // R2
        PSCS_RESET: error_reset_line_oe <= ~pin.reconfig; // R9
        PSCS_ERROR: error_reset_line_oe <= 1'b1; // R21
        default:    error_reset_line_oe <= 1'b0; // R6
      endcase
      load_complete_line_oe <= (stage_r != PSCS_STARTUP) &&
                               (stage_r != PSCS_USER); // R13
      startup_done_line_oe  <= done_en_r && (stage_r == PSCS_LOAD ||
                               stage_r == PSCS_STARTUP); // R18
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      user_io_tristate <= 1'b1;
      weak_pullup_en   <= 1'b0;
      user_mode        <= 1'b0;
    end else begin
      user_io_tristate <= (stage_r != PSCS_USER); // R2
      weak_pullup_en   <= !pin.pull_dis && stage_r != PSCS_POR &&
                          stage_r != PSCS_USER; // R7
      user_mode        <= (stage_r == PSCS_USER); // R19
    end
  end

endmodule : pscs_top

// *** testbench/pscs_loader_model.sv ***
`timescale 1ns/1ps
// ************************
// Serial loader model
// ************************
module pscs_loader_model #(
  parameter int POR_NS = 5000
) (
  // Wire levels seen
  input  wire logic        error_line,
  input  wire logic        load_done,
  // Image, first bit at the top
  input  wire logic [31:0] image,
  // Driven lines
  output logic             gate_oe,
  output logic             bclk,
  output logic             data
);
  int i;
  int n;

  initial begin
    gate_oe = 1'b1;
    bclk = 1'b0;
    data = 1'b0;
    #(POR_NS);
    gate_oe = 1'b0;
    forever begin
      wait (error_line && !load_done);
      #2037;
      for (i = 0; i < 32 && error_line; i++) begin
        data = image[31-i];
        #200 bclk = 1'b1;
        #200 bclk = 1'b0;
      end
      // Stale bit never passes for a driven one
      data = ~data;
      n = 0;
      while (error_line && !load_done && n < 64) begin
        #200 bclk = 1'b1;
        #200 bclk = 1'b0;
        n++;
      end
      if (error_line && !load_done) begin
        gate_oe = 1'b1;
        #2000 gate_oe = 1'b0;
      end
      wait (!load_done || !error_line);
    end
  end
endmodule : pscs_loader_model

// *** testbench/pscs_top_properties.sv ***
`timescale 1ns/1ps
// ************************
// Port checker
// ************************
module pscs_props #(
  parameter logic [31:0] POR_SHORT_CYC = 32'h0000_0028,
  parameter logic [31:0] POR_LONG_CYC  = 32'h0000_0064
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Bus answer
  input wire logic pready,
  // Straps and lines
  input wire logic powerup_delay_select,
  input wire logic weak_pullup_disable,
  input wire logic reconfig_request_line,
  input wire logic error_reset_line_o,
  input wire logic error_reset_line_oe,
  input wire logic load_complete_line_o,
  input wire logic load_complete_line_oe,
  input wire logic startup_done_line_o,
  input wire logic startup_done_line_oe,
  // User pins
  input wire logic user_io_tristate,
  input wire logic weak_pullup_en,
  input wire logic user_mode
);
  logic [31:0] por_cnt_r;
  logic [15:0] su_cnt_r;
  logic [31:0] por_lim;

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  assign por_lim = powerup_delay_select ? POR_SHORT_CYC : POR_LONG_CYC;

  // Saturating, so a long run never wraps into the window
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) por_cnt_r <= 32'h0000_0000;
    else if (por_cnt_r != 32'hFFFF_FFFF) por_cnt_r <= por_cnt_r + 1'b1;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) su_cnt_r <= 16'h0000;
    else if (load_complete_line_oe) su_cnt_r <= 16'h0000;
    else if (su_cnt_r != 16'hFFFF) su_cnt_r <= su_cnt_r + 1'b1;
  end

  sequence cfg_drop_s;
    $fell(reconfig_request_line) ##1 !reconfig_request_line [*4];
  endsequence
  sequence cfg_held_s;
    error_reset_line_oe && load_complete_line_oe && user_io_tristate;
  endsequence

  por_hold_a: assert property (
    por_cnt_r < por_lim |->
      error_reset_line_oe && user_io_tristate && !weak_pullup_en)
    else $error("power-on hold broken");
  od_drive_a: assert property (
    !error_reset_line_o && !load_complete_line_o && !startup_done_line_o)
    else $error("open-drain line driven high");
  cfg_reset_a: assert property (
    cfg_drop_s |-> ##[0:6] cfg_held_s)
    else $error("reconfig low did not reset");
  pins_tri_a: assert property (
    user_io_tristate == !user_mode)
    else $error("tristate does not follow user mode");
  user_pull_a: assert property (
    user_mode |-> !weak_pullup_en)
    else $error("pull-ups on in user mode");
  pull_dis_a: assert property (
    weak_pullup_disable [*6] |-> !weak_pullup_en)
    else $error("pull-ups on while disabled");
  start_len_a: assert property (
    $rose(user_mode) |-> !load_complete_line_oe && su_cnt_r >= 16'h0186)
    else $error("user mode too early");
  done_line_a: assert property (
    $rose(user_mode) |=> !startup_done_line_oe)
    else $error("start-up done line not released");
  load_err_a: assert property (
    $fell(load_complete_line_oe) |-> !error_reset_line_oe)
    else $error("load complete during error");
  apb_pulse_a: assert property (
    pready |=> !pready)
    else $error("ready longer than one cycle");
endmodule : pscs_props

bind pscs_top pscs_props #(
  .POR_SHORT_CYC(POR_SHORT_CYC),
  .POR_LONG_CYC (POR_LONG_CYC)
) u_props (
  .clk                  (clk),
  .nrst                 (nrst),
  .pready               (pready),
  .powerup_delay_select (powerup_delay_select),
  .weak_pullup_disable  (weak_pullup_disable),
  .reconfig_request_line(reconfig_request_line),
  .error_reset_line_o   (error_reset_line_o),
  .error_reset_line_oe  (error_reset_line_oe),
  .load_complete_line_o (load_complete_line_o),
  .load_complete_line_oe(load_complete_line_oe),
  .startup_done_line_o  (startup_done_line_o),
  .startup_done_line_oe (startup_done_line_oe),
  .user_io_tristate     (user_io_tristate),
  .weak_pullup_en       (weak_pullup_en),
  .user_mode            (user_mode)
);

// *** testbench/tb_top.sv ***
`timescale 1ns/1ps
// ************************
// Bench
// ************************
module tb_top;
  localparam int POR_S = 40;
  localparam int RST_C = 60;
  localparam int POR_L = 100;
  logic        pds = 1'b1;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] paddr = 32'h0000_0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready, pslverr;
  logic        wpd = 1'b0;
  logic        recfg = 1'b1;
  logic        pull_r = 1'b0;
  logic        uclk = 1'b0;
  logic [2:0]  ucnt = 3'h0;
  logic [31:0] image = 32'hA508_1234;
  logic        err_o, err_oe, lc_o, lc_oe, sd_o, sd_oe, gate_oe;
  logic        bclk, din, tri_o, pu_en, umode;
  wire         err_w, lc_w;
  int          cyc = 0;
  int          fail_count = 0;
  int          comparisons = 0;

  always #25 clk = ~clk;
  always @(posedge clk) if (nrst) cyc <= cyc + 1;
  // Runs through loading too, which must not care
  always @(posedge clk) begin
    ucnt <= (ucnt == 3'h2) ? 3'h0 : ucnt + 3'h1;
    if (ucnt == 3'h2) uclk <= ~uclk;
  end
  assign err_w = !(err_oe | gate_oe | pull_r);
  assign lc_w = !lc_oe;

  pscs_top #(
    .POR_LONG_CYC (32'h0000_0064),
    .POR_SHORT_CYC(32'h0000_0028),
    .RESTART_CYC  (32'h0000_003C)
  ) dut (
    .clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .powerup_delay_select(pds),
    .weak_pullup_disable(wpd), .reconfig_request_line(recfg),
    .error_reset_line_i(err_w), .error_reset_line_o(err_o),
    .error_reset_line_oe(err_oe), .load_complete_line_o(lc_o),
    .load_complete_line_oe(lc_oe), .startup_done_line_o(sd_o),
    .startup_done_line_oe(sd_oe), .serial_bit_clock(bclk),
    .serial_bit_in(din), .external_startup_clock(uclk),
    .user_io_tristate(tri_o), .weak_pullup_en(pu_en), .user_mode(umode)
  );
  // Loader outlasts the target's power-on
  pscs_loader_model #(.POR_NS(5000)) u_ldr (
    .error_line(err_w), .load_done(lc_w), .image(image),
    .gate_oe(gate_oe), .bclk(bclk), .data(din)
  );

  task automatic chk(input string nm, input logic [31:0] s, e);
    comparisons++;
    if (s !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic chkb(input string nm, input logic b);
    chk(nm, {31'h0000_0000, b}, 32'h0000_0001);
  endtask : chkb
  task automatic apb(input logic w, input logic [31:0] a, d,
                     output logic [31:0] q, output logic e);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    chkb("pready", pready === 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdc(input string nm, input logic [31:0] a, x);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0000_0000, q, e);
    chk(nm, q, x);
  endtask : rdc
  task automatic wr(input logic [31:0] a, d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask : wr
  task automatic wt(input int s, input logic v, output int n);
    logic x;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      x = (s == 0) ? err_oe : (s == 1) ? lc_oe : umode;
    end while (x !== v && n < 40000);
    chkb("wait", x === v);
  endtask : wt

  task automatic t_regs;
    logic [31:0] q;
    logic        e;
    rdc("stage", 32'h0000_0008, 32'h0000_0000);
    rdc("ctrl", 32'h0000_0000, 32'h0000_0000);
    rdc("length", 32'h0000_0004, 32'h0000_1000);
    apb(1'b0, 32'h0000_0010, 32'h0000_0000, q, e);
    chkb("unmapped", e === 1'b1 && q === 32'h0000_0000);
    wr(32'h0000_000C, 32'h0000_0005);
    rdc("bitcnt", 32'h0000_000C, 32'h0000_0000);
    wr(32'h0000_0004, 32'h0000_0020);
  endtask : t_regs
  task automatic t_por;
    int n;
    wt(0, 1'b0, n);
    chkb("por len", cyc >= POR_S && cyc <= POR_S + 6);
    chkb("pullup", pu_en === 1'b1 && tri_o === 1'b1);
    rdc("held", 32'h0000_0008, 32'h0000_0001);
  endtask : t_por
  task automatic t_load;
    int n;
    wt(1, 1'b0, n);
    chkb("done en", sd_oe === 1'b1);
    wt(2, 1'b1, n);
    chkb("startup", n >= 395 && n <= 420);
    chkb("user pins", tri_o === 1'b0 && pu_en === 1'b0);
    rdc("bits", 32'h0000_000C, 32'h0000_0020);
    rdc("status", 32'h0000_0008, 32'h0000_000C);
  endtask : t_load
  task automatic t_recfg;
    int n;
    wpd <= 1'b1;
    recfg <= 1'b0;
    pull_r <= 1'b1;
    repeat (10) @(posedge clk);
    chkb("reset", err_oe === 1'b1 && lc_oe === 1'b1 && tri_o === 1'b1);
    chkb("pull off", pu_en === 1'b0);
    wr(32'h0000_0000, 32'h0000_0001);
    recfg <= 1'b1;
    repeat (100) @(posedge clk);
    chkb("released", err_oe === 1'b0);
    rdc("postponed", 32'h0000_0008, 32'h0000_0001);
    pull_r <= 1'b0;
    wpd <= 1'b0;
    wt(1, 1'b0, n);
    wt(2, 1'b1, n);
    chkb("ext", n >= 32 + 4435 * 6 && n <= 32 + 4437 * 6 + 40);
  endtask : t_recfg
  task automatic t_err;
    int          n;
    logic [31:0] q;
    logic        e;
    wr(32'h0000_0000, 32'h0000_0002);
    image <= 32'h5A08_1234;
    recfg <= 1'b0;
    repeat (10) @(posedge clk);
    recfg <= 1'b1;
    wt(0, 1'b0, n);
    wt(0, 1'b1, n);
    image <= 32'hA508_1234;
    apb(1'b0, 32'h0000_0008, 32'h0000_0000, q, e);
    chkb("error", q[4] === 1'b1 && q[2:0] === 3'h5);
    wt(0, 1'b0, n);
    chkb("restart", n >= RST_C - 8 && n <= RST_C + 8);
    wt(2, 1'b1, n);
    wr(32'h0000_0008, 32'h0000_0010);
    apb(1'b0, 32'h0000_0008, 32'h0000_0000, q, e);
    chkb("clear", q[4] === 1'b0 && q[2:0] === 3'h4);
  endtask : t_err
  // Strap low only takes hold through a fresh power-on
  task automatic t_por_long;
    int n;
    pds <= 1'b0;
    nrst <= 1'b0;
    repeat (3) @(posedge clk);
    chkb("rst lines", err_oe === 1'b1 && lc_oe === 1'b1);
    chkb("rst user", umode === 1'b0 && tri_o === 1'b1);
    nrst <= 1'b1;
    wt(0, 1'b0, n);
    chkb("por long", n >= POR_L && n <= POR_L + 6);
  endtask : t_por_long

  task automatic conclude;
    $display("checks %0d errors %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude

  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    t_regs();
    t_por();
    t_load();
    t_recfg();
    t_err();
    t_por_long();
    conclude();
  end
  initial begin
    #3000000;
    fail_count++;
    conclude();
  end
endmodule : tb_top
